// *** src/smc_mode_ctrl.sv ***
`timescale 1ns/100ps
// Summary of operation
// - fast ready flag is 0 at power-on, rises only once fast oscillator settles
// - fast ready flag held low during sleep and clock-stopped idle
// - after wake fast ready rises after 128 crystal or 16 RC cycles
// - halt with idle select set enters an idle mode
// - clock-running idle stops the CPU but keeps the system clock
// - idle with clock keep low stops CPU and system clock
// - halt with idle select clear enters sleep
// - clock select 1 picks undivided fast clock, 0 picks divided or slow
// - moving from fast to slow clock switches the fast oscillator off
// - divider codes 000/001 slow clock, 010..111 fast clock /64 to /2
// - fast wake with crystal runs from slow clock until fast is ready, except out of deep sleep
// - clock keep bit enables the system clock during idle
module smc_mode_ctrl
    import smc_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    // register port
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [DATA_W-1:0] regWrData,
    input  wire logic              regWrStb,
    input  wire logic              regRdStb,
    output logic      [DATA_W-1:0] regRdData_r,
    // core events
    input  wire logic              haltExec,
    input  wire logic              wakeEvent,
    // configuration levels
    input  wire logic              hsIsCrystal,
    input  wire logic              lsKeepOn,
    // reset cause events
    input  wire logic              lowVoltEvent,
    input  wire logic              voltSetEvent,
    input  wire logic              wdtSetEvent,
    // oscillator clock pins
    input  wire logic              hsOscPin,
    input  wire logic              lsOscPin,
    // clock and power control
    output logic                   cpuRun_r,
    output logic                   sysClkRun_r,
    output logic                   sysClkUndiv_r,
    output logic                   lowSpeedSel_r,
    output logic      [2:0]        divSel_r,
    output logic                   hsOscEn_r,
    output logic                   lsOscEn_r,
    output smc_mode_type           opMode_r
);
    import smc_pkg::*;

    // software-held control bits
    logic [2:0]       clkDiv_r, clkDiv_nxt;
    logic             fastWakeEn_r, fastWakeEn_nxt;
    logic             idleSel_r, idleSel_nxt;
    logic             clkSel_r, clkSel_nxt;
    logic             idleKeep_r, idleKeep_nxt;
    logic             lvrFlag_r, lvrFlag_nxt;
    logic             voltFlag_r, voltFlag_nxt;
    logic             wdtFlag_r, wdtFlag_nxt;
    logic [DATA_W-1:0] rdData_nxt;

    // mode and clock state
    smc_mode_type     opMode_nxt;
    logic             fastWake_r, fastWake_nxt;
    logic             cpuRun_nxt, sysClkRun_nxt;
    logic             sysClkUndiv_nxt, lowSpeedSel_nxt;
    logic [2:0]       divSel_nxt;
    logic             hsOscEn_nxt, lsOscEn_nxt;

    // oscillator status
    logic             hsTick, lsTick;
    logic             hsReady, lsReady;
    logic [CNT_W-1:0] hsLimit;
    logic             slowPick, clkReady;
    logic             modeWr, flagWr;

    // oscillator pins cross into the clock domain
    smc_sync2 u_hsSync (
        .clk       (clk),
        .srst      (srst),
        .asyncIn   (hsOscPin),
        .risePulse (hsTick)
    );

    smc_sync2 u_lsSync (
        .clk       (clk),
        .srst      (srst),
        .asyncIn   (lsOscPin),
        .risePulse (lsTick)
    );

    // settle count depends on the fast source
    assign hsLimit = hsIsCrystal ? HS_XTAL_CYC : HS_RC_CYC;

    // fast ready flag follows the fast oscillator enable
    smc_ready_timer u_hsReady (
        .clk     (clk),
        .srst    (srst),
        .oscEn   (hsOscEn_r),
        .oscTick (hsTick),
        .limit   (hsLimit),
        .ready_r (hsReady)
    );

    // slow ready flag follows the slow oscillator enable
    smc_ready_timer u_lsReady (
        .clk     (clk),
        .srst    (srst),
        .oscEn   (lsOscEn_r),
        .oscTick (lsTick),
        .limit   (LS_CYC),
        .ready_r (lsReady)
    );

    // selected clock and its readiness
    assign slowPick = smcUsesLowSpeed(clkSel_r, clkDiv_r) || fastWake_r;
    assign clkReady = slowPick ? lsReady : hsReady;
    assign modeWr   = regWrStb && regAddr == ADDR_MODE;
    assign flagWr   = regWrStb && regAddr == ADDR_FLAGS;

    // register writes; reset cause flags only clear, events win
    always_comb begin
        clkDiv_nxt     = clkDiv_r;
        fastWakeEn_nxt = fastWakeEn_r;
        idleSel_nxt    = idleSel_r;
        clkSel_nxt     = clkSel_r;
        idleKeep_nxt   = idleKeep_r;
        lvrFlag_nxt    = lvrFlag_r;
        voltFlag_nxt   = voltFlag_r;
        wdtFlag_nxt    = wdtFlag_r;
        if (modeWr) begin
            clkDiv_nxt     = regWrData[DIV_MSB:DIV_LSB];
            fastWakeEn_nxt = regWrData[FASTWAKE_BIT];
            idleSel_nxt    = regWrData[IDLE_BIT];
            clkSel_nxt     = regWrData[CLKSEL_BIT];
        end
        if (flagWr) begin
            idleKeep_nxt = regWrData[KEEP_BIT];
            lvrFlag_nxt  = lvrFlag_r && regWrData[LOWVF_BIT];
            voltFlag_nxt = voltFlag_r && regWrData[VSETF_BIT];
            wdtFlag_nxt  = wdtFlag_r && regWrData[WDTF_BIT];
        end
        lvrFlag_nxt  = lvrFlag_nxt || lowVoltEvent;
        voltFlag_nxt = voltFlag_nxt || voltSetEvent;
        wdtFlag_nxt  = wdtFlag_nxt || wdtSetEvent;
    end

    // read data for the cycle after the strobe; unmapped reads zero
    always_comb begin
        rdData_nxt = '0;
        if (regRdStb) begin
            unique case (regAddr)
                ADDR_MODE: begin
                    rdData_nxt[DIV_MSB:DIV_LSB] = clkDiv_r;
                    rdData_nxt[FASTWAKE_BIT]    = fastWakeEn_r;
                    rdData_nxt[LSRDY_BIT]       = lsReady;
                    rdData_nxt[HSRDY_BIT]       = hsReady;
                    rdData_nxt[IDLE_BIT]        = idleSel_r;
                    rdData_nxt[CLKSEL_BIT]      = clkSel_r;
                end
                ADDR_FLAGS: begin
                    rdData_nxt[KEEP_BIT]  = idleKeep_r;
                    rdData_nxt[LOWVF_BIT] = lvrFlag_r;
                    rdData_nxt[VSETF_BIT] = voltFlag_r;
                    rdData_nxt[WDTF_BIT]  = wdtFlag_r;
                end
                default: rdData_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            clkDiv_r     <= DIV_RESET;
            fastWakeEn_r <= MODE_RESET[FASTWAKE_BIT];
            idleSel_r    <= MODE_RESET[IDLE_BIT];
            clkSel_r     <= MODE_RESET[CLKSEL_BIT];
            idleKeep_r   <= FLAGS_RESET[KEEP_BIT];
            lvrFlag_r    <= FLAGS_RESET[LOWVF_BIT];
            voltFlag_r   <= FLAGS_RESET[VSETF_BIT];
            wdtFlag_r    <= FLAGS_RESET[WDTF_BIT];
            regRdData_r  <= '0;
        end else begin
            clkDiv_r     <= clkDiv_nxt;
            fastWakeEn_r <= fastWakeEn_nxt;
            idleSel_r    <= idleSel_nxt;
            clkSel_r     <= clkSel_nxt;
            idleKeep_r   <= idleKeep_nxt;
            lvrFlag_r    <= lvrFlag_nxt;
            voltFlag_r   <= voltFlag_nxt;
            wdtFlag_r    <= wdtFlag_nxt;
            regRdData_r  <= rdData_nxt;
        end
    end

    // mode sequencing on halt and wake
    always_comb begin
        opMode_nxt   = opMode_r;
        fastWake_nxt = fastWake_r && !hsReady;
        unique case (opMode_r)
            SMC_RUN: begin
                if (haltExec) begin
                    if (!idleSel_r)
                        opMode_nxt = SMC_SLEEP;
                    else if (idleKeep_r)
                        opMode_nxt = SMC_IDLE_RUN;
                    else
                        opMode_nxt = SMC_IDLE_STOP;
                end
            end
            SMC_IDLE_RUN: begin
                if (wakeEvent)
                    opMode_nxt = SMC_RUN;
            end
            SMC_IDLE_STOP, SMC_SLEEP: begin
                if (wakeEvent) begin
                    opMode_nxt = SMC_RUN;
                    // slow clock stands in only while it is alive
                    fastWake_nxt = fastWakeEn_r && hsIsCrystal && lsOscEn_r
                                   && !smcUsesLowSpeed(clkSel_r, clkDiv_r);
                end
            end
        endcase
    end

    // clock gating, source selection and oscillator enables
    always_comb begin
        cpuRun_nxt      = opMode_r == SMC_RUN && clkReady;
        sysClkRun_nxt   = (opMode_r == SMC_RUN || opMode_r == SMC_IDLE_RUN)
                          && clkReady;
        sysClkUndiv_nxt = clkSel_r && !fastWake_r;
        lowSpeedSel_nxt = slowPick;
        divSel_nxt      = clkDiv_r;
        // fast oscillator off when the slow clock is chosen or asleep
        hsOscEn_nxt     = (opMode_r == SMC_RUN || opMode_r == SMC_IDLE_RUN)
                          && (!smcUsesLowSpeed(clkSel_r, clkDiv_r) || fastWake_r);
        // slow oscillator stops only in deep sleep
        lsOscEn_nxt     = !(opMode_r == SMC_SLEEP && !lsKeepOn);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            opMode_r      <= SMC_RUN;
            fastWake_r    <= 1'b0;
            cpuRun_r      <= 1'b0;
            sysClkRun_r   <= 1'b0;
            sysClkUndiv_r <= MODE_RESET[CLKSEL_BIT];
            lowSpeedSel_r <= 1'b0;
            divSel_r      <= DIV_RESET;
            hsOscEn_r     <= 1'b0;
            lsOscEn_r     <= 1'b0;
        end else begin
            opMode_r      <= opMode_nxt;
            fastWake_r    <= fastWake_nxt;
            cpuRun_r      <= cpuRun_nxt;
            sysClkRun_r   <= sysClkRun_nxt;
            sysClkUndiv_r <= sysClkUndiv_nxt;
            lowSpeedSel_r <= lowSpeedSel_nxt;
            divSel_r      <= divSel_nxt;
            hsOscEn_r     <= hsOscEn_nxt;
            lsOscEn_r     <= lsOscEn_nxt;
        end
    end

    // checks on mode entry
    a_halt_to_sleep: assert property (@(posedge clk) disable iff (srst)
        opMode_r == SMC_RUN && haltExec && !idleSel_r |=> opMode_r == SMC_SLEEP)
        else $error("halt with idle clear did not enter sleep");

    a_halt_to_idle: assert property (@(posedge clk) disable iff (srst)
        opMode_r == SMC_RUN && haltExec && idleSel_r
        |=> opMode_r == (idleKeep_r ? SMC_IDLE_RUN : SMC_IDLE_STOP))
        else $error("halt with idle set did not enter the right idle");

    // checks on clock gating in idle
    a_idle_clock_kept: assert property (@(posedge clk) disable iff (srst)
        opMode_r == SMC_IDLE_RUN && clkReady |=> sysClkRun_r && !cpuRun_r)
        else $error("clock-running idle lost clock or kept cpu");

    a_idle_clock_stop: assert property (@(posedge clk) disable iff (srst)
        opMode_r == SMC_IDLE_STOP |=> !sysClkRun_r && !cpuRun_r)
        else $error("clock-stopped idle left a clock running");

    // fast ready flag low while asleep
    a_hto_low_asleep: assert property (@(posedge clk) disable iff (srst)
        (opMode_r == SMC_SLEEP || opMode_r == SMC_IDLE_STOP) [*3] |-> !hsReady)
        else $error("fast ready flag high while asleep");

    // slow selection shuts the fast oscillator
    a_hs_off_slow: assert property (@(posedge clk) disable iff (srst)
        smcUsesLowSpeed(clkSel_r, clkDiv_r) && !fastWake_r |=> !hsOscEn_r)
        else $error("fast oscillator left on with slow clock");

    // source selection follows the control bits
    a_undiv_select: assert property (@(posedge clk) disable iff (srst)
        clkSel_r && !fastWake_r |=> sysClkUndiv_r && !lowSpeedSel_r)
        else $error("undivided fast clock not selected");

    a_div_select: assert property (@(posedge clk) disable iff (srst)
        !clkSel_r && !fastWake_r
        |=> divSel_r == $past(clkDiv_r) && lowSpeedSel_r == ($past(clkDiv_r) < DIV_FIRST_FAST))
        else $error("divider code gave the wrong source");

    // fast wake runs from the slow clock until the fast one settles
    a_fast_wake_slow: assert property (@(posedge clk) disable iff (srst)
        opMode_r == SMC_SLEEP && wakeEvent && fastWakeEn_r && hsIsCrystal
        && lsOscEn_r && clkSel_r |=> fastWake_r ##1 (lowSpeedSel_r && !sysClkUndiv_r))
        else $error("fast wake did not borrow the slow clock");

    // slow oscillator and its flag stop in deep sleep
    a_lto_deep_sleep: assert property (@(posedge clk) disable iff (srst)
        opMode_r == SMC_SLEEP && !lsKeepOn ##1 opMode_r == SMC_SLEEP
        |=> !lsOscEn_r && !lsReady)
        else $error("slow ready flag high in deep sleep");

    // a set event beats a software clear
    a_flag_set_wins: assert property (@(posedge clk) disable iff (srst)
        lowVoltEvent |=> lvrFlag_r)
        else $error("low voltage flag lost its set");
endmodule // smc_mode_ctrl

// *** src/smc_pkg.sv ***
package smc_pkg;
    // register port geometry
    localparam int          DATA_W       = 8;
    localparam int          ADDR_W       = 2;
    localparam logic [1:0]  ADDR_MODE    = 2'h0;
    localparam logic [1:0]  ADDR_FLAGS   = 2'h1;

    // mode register field positions
    localparam int          CLKSEL_BIT   = 0;
    localparam int          IDLE_BIT     = 1;
    localparam int          HSRDY_BIT    = 2;
    localparam int          LSRDY_BIT    = 3;
    localparam int          FASTWAKE_BIT = 4;
    localparam int          DIV_LSB      = 5;
    localparam int          DIV_MSB      = 7;

    // flag register field positions
    localparam int          WDTF_BIT     = 0;
    localparam int          VSETF_BIT    = 1;
    localparam int          LOWVF_BIT    = 2;
    localparam int          KEEP_BIT     = 7;

    // reset values
    localparam logic [7:0]  MODE_RESET   = 8'h03;
    localparam logic [7:0]  FLAGS_RESET  = 8'h00;
    localparam logic [2:0]  DIV_RESET    = 3'h0;

    // lowest divider code that still selects the fast clock
    localparam logic [2:0]  DIV_FIRST_FAST = 3'h2;

    // oscillator settle counts, in oscillator cycles
    localparam int          CNT_W        = 8;
    localparam logic [7:0]  HS_XTAL_CYC  = 8'h80;
    localparam logic [7:0]  HS_RC_CYC    = 8'h10;
    localparam logic [7:0]  LS_CYC       = 8'h02;
    localparam logic [7:0]  CNT_ZERO     = 8'h00;
    localparam logic [7:0]  CNT_ONE      = 8'h01;

    // operating modes
    typedef enum logic [1:0] {
        SMC_RUN,
        SMC_IDLE_RUN,
        SMC_IDLE_STOP,
        SMC_SLEEP
    } smc_mode_type;

    // true when the selection leaves the fast clock unused
    function automatic logic smcUsesLowSpeed(input logic clkSel, input logic [2:0] divCode);
        return !clkSel && (divCode < DIV_FIRST_FAST);
    endfunction
endpackage

// *** src/smc_sync2.sv ***
`timescale 1ns/100ps
module smc_sync2 (
    // clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // pin side
    input  wire logic asyncIn,
    // clock side
    output logic      risePulse
);
    logic stage1_r, stage2_r, stage3_r;
    logic stage1_nxt, stage2_nxt, stage3_nxt;

    // two flops for the crossing, a third for edge finding
    always_comb begin
        stage1_nxt = asyncIn;
        stage2_nxt = stage1_r;
        stage3_nxt = stage2_r;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            stage1_r <= 1'b0;
            stage2_r <= 1'b0;
            stage3_r <= 1'b0;
        end else begin
            stage1_r <= stage1_nxt;
            stage2_r <= stage2_nxt;
            stage3_r <= stage3_nxt;
        end
    end

    assign risePulse = stage2_r && !stage3_r;
endmodule // smc_sync2

// *** src/smc_ready_timer.sv ***
`timescale 1ns/100ps
module smc_ready_timer
    import smc_pkg::*;
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             srst,
    // oscillator state
    input  wire logic             oscEn,
    input  wire logic             oscTick,
    input  wire logic [CNT_W-1:0] limit,
    // ready flag
    output logic                  ready_r
);
    logic [CNT_W-1:0] count_r, count_nxt;
    logic             ready_nxt;

    // count oscillator cycles while running, restart when stopped
    always_comb begin
        count_nxt = count_r;
        if (!oscEn)
            count_nxt = CNT_ZERO;
        else if (oscTick && count_r < limit)
            count_nxt = count_r + CNT_ONE;
        ready_nxt = oscEn && (count_r >= limit);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            count_r <= CNT_ZERO;
            ready_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            ready_r <= ready_nxt;
        end
    end

    a_ready_after_count: assert property (@(posedge clk) disable iff (srst)
        $rose(ready_r) |-> $past(count_r) >= $past(limit))
        else $error("ready flag rose before the settle count");
    a_ready_off_low: assert property (@(posedge clk) disable iff (srst)
        !oscEn |=> !ready_r && count_r == CNT_ZERO)
        else $error("ready flag high with oscillator stopped");
endmodule // smc_ready_timer

// *** verification/smc_mode_ctrl_bench.sv ***
`timescale 1ns/100ps
// compare two values, count the check and report a mismatch at once
`define SMC_CHK(got, exp) begin nChecks++; if ((got) !== (exp)) begin failCount++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

module smc_mode_ctrl_bench;
    import smc_pkg::*;

    // design ports
    logic               clk;
    logic               srst;
    logic [ADDR_W-1:0]  regAddr;
    logic [DATA_W-1:0]  regWrData;
    logic               regWrStb;
    logic               regRdStb;
    logic [DATA_W-1:0]  regRdData_r;
    logic               haltExec;
    logic               wakeEvent;
    logic               hsIsCrystal;
    logic               lsKeepOn;
    logic               lowVoltEvent;
    logic               voltSetEvent;
    logic               wdtSetEvent;
    logic               hsOscPin;
    logic               lsOscPin;
    logic               cpuRun_r;
    logic               sysClkRun_r;
    logic               sysClkUndiv_r;
    logic               lowSpeedSel_r;
    logic [2:0]         divSel_r;
    logic               hsOscEn_r;
    logic               lsOscEn_r;
    smc_mode_type       opMode_r;
    // bench state
    int                 failCount;
    int                 nChecks;
    logic [3:0]         hsDiv;
    logic [3:0]         lsDiv;
    logic [7:0]         rd;
    int                 cyc;

    // divider table rows: mode write and expected {slow, undivided, fast enable, divider}
    localparam logic [7:0] ROW_DATA [9] = '{8'hE0, 8'hC0, 8'hA0, 8'h80, 8'h60, 8'h40,
                                            8'h20, 8'h00, 8'h01};
    localparam logic [5:0] ROW_EXP  [9] = '{6'h0F, 6'h0E, 6'h0D, 6'h0C, 6'h0B, 6'h0A,
                                            6'h21, 6'h20, 6'h18};

    smc_mode_ctrl DUT (
        .clk           (clk),
        .srst          (srst),
        .regAddr       (regAddr),
        .regWrData     (regWrData),
        .regWrStb      (regWrStb),
        .regRdStb      (regRdStb),
        .regRdData_r   (regRdData_r),
        .haltExec      (haltExec),
        .wakeEvent     (wakeEvent),
        .hsIsCrystal   (hsIsCrystal),
        .lsKeepOn      (lsKeepOn),
        .lowVoltEvent  (lowVoltEvent),
        .voltSetEvent  (voltSetEvent),
        .wdtSetEvent   (wdtSetEvent),
        .hsOscPin      (hsOscPin),
        .lsOscPin      (lsOscPin),
        .cpuRun_r      (cpuRun_r),
        .sysClkRun_r   (sysClkRun_r),
        .sysClkUndiv_r (sysClkUndiv_r),
        .lowSpeedSel_r (lowSpeedSel_r),
        .divSel_r      (divSel_r),
        .hsOscEn_r     (hsOscEn_r),
        .lsOscEn_r     (lsOscEn_r),
        .opMode_r      (opMode_r)
    );

    // 10 MHz system clock
    always #50 clk = ~clk;

    // oscillator pins only toggle while enabled; fast period 4 clk, slow 16 clk
    always @(posedge clk) begin
        if (hsOscEn_r === 1'b1) hsDiv <= hsDiv + 4'h1;
        if (lsOscEn_r === 1'b1) lsDiv <= lsDiv + 4'h1;
        hsOscPin <= hsDiv[1];
        lsOscPin <= lsDiv[3];
    end

    // closing report, the only place the run ends
    task automatic wrapUp();
        $display("checks=%0d mismatches=%0d", nChecks, failCount);
        if (failCount == 0 && nChecks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // let n edges pass and step off the edge
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // one-cycle register write
    task automatic regWrite(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr   <= a;
        regWrData <= d;
        regWrStb  <= 1'b1;
        @(posedge clk);
        regWrStb  <= 1'b0;
    endtask

    // one-cycle register read, data taken in the following cycle
    task automatic regRead(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr  <= a;
        regRdStb <= 1'b1;
        @(posedge clk);
        regRdStb <= 1'b0;
        #1;
        d = regRdData_r;
    endtask

    // one-cycle event pulse: {halt, wake, low volt, volt setting, watchdog setting}
    task automatic evt(input logic [4:0] m);
        @(posedge clk);
        {haltExec, wakeEvent, lowVoltEvent, voltSetEvent, wdtSetEvent} <= m;
        @(posedge clk);
        {haltExec, wakeEvent, lowVoltEvent, voltSetEvent, wdtSetEvent} <= 5'h00;
    endtask

    // poll the fast ready bit under a bound, returning elapsed cycles
    task automatic waitReady(output int n);
        logic [7:0] d;
        n = 0;
        d = 8'h00;
        while (d[2] !== 1'b1) begin
            regRead(ADDR_MODE, d);
            n += 2;
            if (n > 2000) begin
                failCount++;
                $display("[ERR] t=%0t got=%0h exp=%0h", $time, d, 8'h04);
                wrapUp();
            end
        end
    endtask

    // halt, then check the mode and {cpu run, system clock run, fast enable}
    task automatic haltCheck(input smc_mode_type m, input logic [2:0] g);
        evt(5'h10);
        settle(3);
        `SMC_CHK(opMode_r, m)
        `SMC_CHK({cpuRun_r, sysClkRun_r, hsOscEn_r}, g)
    endtask

    initial begin
        clk = 1'b0; srst = 1'b1; regAddr = 2'h0; regWrData = 8'h00;
        regWrStb = 1'b0; regRdStb = 1'b0; haltExec = 1'b0; wakeEvent = 1'b0;
        hsIsCrystal = 1'b1; lsKeepOn = 1'b1; lowVoltEvent = 1'b0;
        voltSetEvent = 1'b0; wdtSetEvent = 1'b0; hsOscPin = 1'b0; lsOscPin = 1'b0;
        hsDiv = 4'h0; lsDiv = 4'h0; failCount = 0; nChecks = 0;
        repeat (2) @(posedge clk);
        srst <= 1'b0;

        // reset values, unmapped index, power-on settle of the crystal
        regRead(ADDR_MODE, rd);
        `SMC_CHK(rd, MODE_RESET)
        settle(1);
        `SMC_CHK(regRdData_r, 8'h00)
        regRead(ADDR_FLAGS, rd);
        `SMC_CHK(rd, FLAGS_RESET)
        regWrite(2'h2, 8'hFF);
        regRead(2'h2, rd);
        `SMC_CHK(rd, 8'h00)
        waitReady(cyc);
        `SMC_CHK(cyc >= 4 * int'(HS_XTAL_CYC) - 8, 1'b1)
        `SMC_CHK(cyc <= 4 * int'(HS_XTAL_CYC) + 16, 1'b1)
        regWrite(ADDR_MODE, 8'h03);
        regRead(ADDR_MODE, rd);
        `SMC_CHK(rd[2], 1'b1)
        $display("test reset done");

        // clock selection table, ending back on the undivided fast clock
        hsIsCrystal <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            regWrite(ADDR_MODE, ROW_DATA[i]);
            settle(3);
            `SMC_CHK({lowSpeedSel_r, sysClkUndiv_r, hsOscEn_r, divSel_r}, ROW_EXP[i])
            regRead(ADDR_MODE, rd);
            `SMC_CHK(rd & 8'hF3, ROW_DATA[i])
        end
        waitReady(cyc);
        $display("test clock select done");

        // reset cause flags: set by events, cleared only by writing 0
        evt(5'h07);
        regRead(ADDR_FLAGS, rd);
        `SMC_CHK(rd, 8'h07)
        regWrite(ADDR_FLAGS, 8'h85);
        regRead(ADDR_FLAGS, rd);
        `SMC_CHK(rd, 8'h85)
        regWrite(ADDR_FLAGS, 8'h00);
        regRead(ADDR_FLAGS, rd);
        `SMC_CHK(rd, 8'h00)
        $display("test flags done");

        // deep sleep from the RC source, timed wake
        lsKeepOn <= 1'b0;
        regWrite(ADDR_MODE, 8'h01);
        haltCheck(SMC_SLEEP, 3'b000);
        `SMC_CHK(lsOscEn_r, 1'b0)
        regRead(ADDR_MODE, rd);
        `SMC_CHK(rd & 8'h0C, 8'h00)
        evt(5'h08);
        waitReady(cyc);
        `SMC_CHK(cyc <= 4 * int'(HS_RC_CYC) + 16, 1'b1)
        `SMC_CHK(cyc >= 4 * int'(HS_RC_CYC) - 8, 1'b1)
        settle(3);
        `SMC_CHK({opMode_r, cpuRun_r}, {SMC_RUN, 1'b1})
        $display("test sleep done");

        // idle with the system clock stopped
        lsKeepOn <= 1'b1;
        regWrite(ADDR_MODE, 8'h03);
        haltCheck(SMC_IDLE_STOP, 3'b000);
        regRead(ADDR_MODE, rd);
        `SMC_CHK(rd[2], 1'b0)
        evt(5'h08);
        waitReady(cyc);
        $display("test idle stop done");

        // idle with the system clock kept running
        regWrite(ADDR_FLAGS, 8'h80);
        haltCheck(SMC_IDLE_RUN, 3'b011);
        evt(5'h08);
        settle(3);
        `SMC_CHK({opMode_r, cpuRun_r}, {SMC_RUN, 1'b1})
        $display("test idle run done");

        // fast wake from sleep with the crystal: slow clock first, then fast
        hsIsCrystal <= 1'b1;
        regWrite(ADDR_FLAGS, 8'h00);
        regWrite(ADDR_MODE, 8'h11);
        settle(40);
        haltCheck(SMC_SLEEP, 3'b000);
        `SMC_CHK(lsOscEn_r, 1'b1)
        evt(5'h08);
        settle(3);
        `SMC_CHK({lowSpeedSel_r, sysClkUndiv_r}, 2'b10)
        waitReady(cyc);
        settle(3);
        `SMC_CHK({lowSpeedSel_r, sysClkUndiv_r}, 2'b01)
        $display("test fast wake done");

        // second reset in mid-run
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        regRead(ADDR_MODE, rd);
        `SMC_CHK(rd, MODE_RESET)
        `SMC_CHK(opMode_r, SMC_RUN)
        $display("test mid reset done");
        wrapUp();
    end
endmodule // smc_mode_ctrl_bench
